//--- shared/wake_cfg_defines.vh
// Register offsets, field positions and reset values of the selective-wake bank
`ifndef WAKE_CFG_DEFINES_VH
`define WAKE_CFG_DEFINES_VH

// Register indices as printed (byte address is four times the index)
`define IDX_SELECTIVE_WAKE_CONTROL    7'h20
`define IDX_WAKE_BIT_TIME_QUANTA      7'h21
`define IDX_WAKE_SAMPLE_POINT         7'h22
`define IDX_WAKE_FRAME_ID_HIGH        7'h23
`define IDX_WAKE_FRAME_ID_UPPER_MID   7'h24
`define IDX_WAKE_FRAME_ID_LOWER_MID   7'h25
`define IDX_WAKE_FRAME_ID_LOW_FLAGS   7'h26
// Added registers: option, interrupt status, interrupt mask, block status
`define IDX_WAKE_OPTION_REGISTER      7'h27
`define IDX_IRQ_STATUS                7'h28
`define IDX_IRQ_MASK                  7'h29
`define IDX_BLOCK_STATUS              7'h2A

// Control register fields
`define CTL_TRIM_EN_BIT               7
`define CTL_UNLOCK_HI                 6
`define CTL_UNLOCK_LO                 5
`define CTL_TO_MASK_BIT               4
`define CTL_VALID_BIT                 0
`define UNLOCK_KEY                    2'h3
`define CTL_WRITE_MASK                8'hF1
`define CTL_RESTART_KEEP              8'hF0

// Reset values
`define RST_CONTROL                   8'h00
`define RST_QUANTA                    8'hA0
`define RST_SAMPLE                    8'h33
`define RST_ID                        8'h00
`define RST_OPTION                    8'h00

// Read masks for reserved bits
`define SAMPLE_MASK                   8'h3F
`define ID_LOW_MASK                   8'h7F

// Interrupt status bit positions
`define IRQ_TIMEOUT_BIT               0
`define IRQ_WAKE_BIT                  1
`define IRQ_CFG_DROP_BIT              2
`define IRQ_WIDTH                     3

`endif

//--- rtl/wake_cfg_regs.v
// Selective-wake configuration register bank with APB slave and interrupt
// What this block does
// - Selective wake enabled only while valid flag set
// - Valid flag self-clears on wake, reset, config change
// - Unlock field counts unlocked only at binary 11
// - Option register writable only while unlocked
// - Bit 7 enables oscillator calibration mode
// - Calibration uses transmit-data pin as trim reference
// - Timeout mask bit gates timeout onto interrupt
// - Timeout status updates only with selective wake enabled
// - Reserved bits always read zero
// - Quanta-per-bit register, reset 1010 0000
// - Quantum length follows clock select field
// - Sample point six-bit fraction, reset 0x33
// - Identifier split over four registers
// - Standard identifier sits in bits 28 to 18
// - Bit 1 selects remote request frame type
// - Bit 0 selects standard or extended identifier
// - Restart clears low nibble; reset clears all
//
// Implementation choice: register access over APB.
`include "wake_cfg_defines.vh"
`default_nettype none

module wake_cfg_regs (
  // Clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Device events (same clock domain)
  input  wire        restart_entry,
  input  wire        wake_event,
  input  wire        bus_timeout_event,
  input  wire [1:0]  quantum_clock_select,
  // Transceiver transmit-data pin (asynchronous)
  input  wire        transceiver_tx_input_pin,
  // Configuration outputs
  output reg         selective_wake_en,
  output reg         oscillator_trim_enable,
  output reg         trim_unlocked,
  output reg         trim_reference,
  output reg  [7:0]  quanta_per_bit,
  output reg  [5:0]  sample_point_fraction,
  output reg  [1:0]  quantum_clock_sel_out,
  output reg  [28:0] wake_frame_id,
  output reg         wake_frame_rtr,
  output reg         wake_frame_ide,
  output reg  [7:0]  wake_option_out,
  output reg         bus_timeout_status,
  output reg         irq
);

  // Overview of the bank as seen from the host
  // Each register is one aligned word; only byte lane 0 carries data
  // Upper data bits always read back as zero
  // The bus answers with no wait states: pready rises in the access phase
  // Unmapped words raise pslverr; such writes change nothing
  // The valid flag is the only gate for selective wake; hardware drops it
  // on wake, restart entry and any change of configuration data
  // The unlock key guards both the trim enable and the option register
  // A locked write is dropped silently so software sees no bus error;
  // the trade-off is that a wrong key is only visible on read back
  // Clock enable low freezes every register, including the synchroniser
  // Outputs trail the internal registers by one clock

  // Word-aligned register index from byte address
  function [6:0] reg_index;
    input [11:0] addr;
    begin
      reg_index = addr[8:2];
    end
  endfunction

  // Byte-lane-0 write merge for 8-bit registers
  function [7:0] merge8;
    input [7:0] old_val;
    input [7:0] new_val;
    input       lane;
    begin
      merge8 = lane ? new_val : old_val;
    end
  endfunction

  // Storage notes
  // Reserved bits are masked on write and again on read, so a stray
  // one can never reach the matching logic downstream
  // Identifier bytes are kept as written, less reserved bit 7 of the low byte; the full identifier is built
  // only at the output stage
  // Interrupt status and mask share one layout

  // Register storage
  reg  [7:0]           ctl_q;      // Control byte
  reg  [7:0]           quanta_q;   // Quanta per bit
  reg  [7:0]           sample_q;   // Sample point
  reg  [7:0]           id_high_q;  // Identifier 28..21
  reg  [7:0]           id_umid_q;  // Identifier 20..13
  reg  [7:0]           id_lmid_q;  // Identifier 12..5
  reg  [7:0]           id_low_q;   // Identifier 4..0, frame type, identifier format
  reg  [7:0]           option_q;   // Low-power receiver option
  reg  [`IRQ_WIDTH-1:0] irq_stat_q; // Sticky interrupt status
  reg  [`IRQ_WIDTH-1:0] irq_mask_q; // Interrupt enables
  reg                  timeout_q;  // Bus timeout status
  // Pin synchroniser: three stages
  reg                  txd_s1_q;
  reg                  txd_s2_q;
  reg                  txd_s3_q;
  reg                  txd_q;      // Filtered pin level

  // Decode notes
  // A transfer is taken only in the access phase and only with clock enable
  // Writes need byte lane 0; other lanes are ignored
  // Misaligned or out-of-range addresses count as unmapped
  // The unlock test uses the key held before the current write

  // Access decode
  wire       access   = psel & penable & clk_en;
  wire       wr       = access & pwrite & pstrb[0];
  wire [6:0] idx      = reg_index(paddr);
  wire       mapped   = (idx >= `IDX_SELECTIVE_WAKE_CONTROL) && (idx <= `IDX_BLOCK_STATUS)
                        && (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
  wire       unlocked = (ctl_q[`CTL_UNLOCK_HI:`CTL_UNLOCK_LO] == `UNLOCK_KEY);

  // Writes to any selective-wake configuration data
  wire cfg_write = wr && mapped && (idx >= `IDX_WAKE_BIT_TIME_QUANTA)
                   && (idx <= `IDX_WAKE_OPTION_REGISTER);
  // Control write is decoded apart and does not count as config change
  wire ctl_wr    = wr && mapped && (idx == `IDX_SELECTIVE_WAKE_CONTROL);
  wire [7:0] ctl_wdata = pwdata[7:0];

  // Valid flag drops: wake, restart, config change
  wire cfg_drop = wake_event | restart_entry | cfg_write;

  // Control byte update order
  // First the host write, then restart clearing, then hardware valid drop
  // Later steps override earlier ones, so a host set of the valid flag
  // that meets a wake or a configuration change is lost on purpose:
  // software must re-validate after every change
  // Reserved bits 3 to 1 are forced to zero on every write

  // Next control byte
  reg [7:0] ctl_d;
  always @* begin
    ctl_d = ctl_q;
    if (ctl_wr) begin
      // Trim enable is only taken while the key was already 11
      if (unlocked) begin
        ctl_d[`CTL_TRIM_EN_BIT] = ctl_wdata[`CTL_TRIM_EN_BIT];
      end
      ctl_d[`CTL_UNLOCK_HI:`CTL_UNLOCK_LO] = ctl_wdata[`CTL_UNLOCK_HI:`CTL_UNLOCK_LO];
      ctl_d[`CTL_TO_MASK_BIT]              = ctl_wdata[`CTL_TO_MASK_BIT];
      ctl_d[`CTL_VALID_BIT]                = ctl_wdata[`CTL_VALID_BIT];
      ctl_d[3:1]                           = 3'h0;
    end
    if (restart_entry) begin
      // Restart keeps upper nibble, clears lower
      ctl_d = ctl_d & `CTL_RESTART_KEEP;
    end
    if (cfg_drop) begin
      // Hardware clear wins over a simultaneous host set
      ctl_d[`CTL_VALID_BIT] = 1'b0;
    end
  end

  // Configuration register notes
  // Each register is written only in its own access phase
  // Sample point and low identifier drop their reserved bits on write
  // The option register keeps its value when the key is not 11
  // Restart leaves these registers untouched; only reset reloads their reset values
  // Power-on reset values are taken from the shared header

  // Control and configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q     <= `RST_CONTROL;
      quanta_q  <= `RST_QUANTA;
      sample_q  <= `RST_SAMPLE;
      id_high_q <= `RST_ID;
      id_umid_q <= `RST_ID;
      id_lmid_q <= `RST_ID;
      id_low_q  <= `RST_ID;
      option_q  <= `RST_OPTION;
    end else if (clk_en) begin
      ctl_q <= ctl_d;
      if (wr && mapped) begin
        case (idx)
          `IDX_WAKE_BIT_TIME_QUANTA: begin
            quanta_q <= merge8(quanta_q, pwdata[7:0], pstrb[0]);
          end
          `IDX_WAKE_SAMPLE_POINT: begin
            sample_q <= pwdata[7:0] & `SAMPLE_MASK;
          end
          `IDX_WAKE_FRAME_ID_HIGH: begin
            id_high_q <= pwdata[7:0];
          end
          `IDX_WAKE_FRAME_ID_UPPER_MID: begin
            id_umid_q <= pwdata[7:0];
          end
          `IDX_WAKE_FRAME_ID_LOWER_MID: begin
            id_lmid_q <= pwdata[7:0];
          end
          `IDX_WAKE_FRAME_ID_LOW_FLAGS: begin
            // Bit 7 reserved, always zero
            id_low_q <= pwdata[7:0] & `ID_LOW_MASK;
          end
          `IDX_WAKE_OPTION_REGISTER: begin
            // Option write granted only with the key at 11
            if (unlocked) begin
              option_q <= pwdata[7:0];
            end
          end
          default: begin
            option_q <= option_q;
          end
        endcase
      end
    end
  end

  // Pin synchroniser notes
  // The transmit-data pin is asynchronous to pclk
  // Three stages settle metastability; only stage 2 reads stage 1
  // A new level is accepted once stages 2 and 3 agree, which also
  // rejects a single-cycle glitch at the cost of one clock of latency
  // Reset sets the stages to the recessive level of the pin

  // Transmit-data pin synchroniser; level accepted when stages 2 and 3 agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_s1_q <= 1'b1;
      txd_s2_q <= 1'b1;
      txd_s3_q <= 1'b1;
      txd_q    <= 1'b1;
    end else if (clk_en) begin
      txd_s1_q <= transceiver_tx_input_pin;
      txd_s2_q <= txd_s1_q;
      txd_s3_q <= txd_s2_q;
      if (txd_s2_q == txd_s3_q) begin
        txd_q <= txd_s3_q;
      end
    end
  end

  // Event notes
  // Events arrive as one-cycle pulses on pclk and need no synchroniser
  // A bus timeout is recorded only while selective wake is valid
  // The timeout interrupt source also needs the mask bit in the control byte
  // A valid-flag drop is reported only if the flag was actually set
  // Wake events are always recorded

  // Bus timeout status and interrupt bookkeeping
  wire       sw_on     = ctl_q[`CTL_VALID_BIT];
  wire       to_update = bus_timeout_event & sw_on;
  wire [`IRQ_WIDTH-1:0] irq_set;
  assign irq_set[`IRQ_TIMEOUT_BIT]  = to_update & ctl_q[`CTL_TO_MASK_BIT];
  assign irq_set[`IRQ_WAKE_BIT]     = wake_event;
  assign irq_set[`IRQ_CFG_DROP_BIT] = sw_on & cfg_drop;
  wire irq_stat_wr = wr && mapped && (idx == `IDX_IRQ_STATUS);
  wire bstat_wr    = wr && mapped && (idx == `IDX_BLOCK_STATUS);

  // Interrupt status notes
  // Bits are sticky and cleared by writing one
  // An event in the same cycle as its clear keeps the bit set, so no
  // event is ever lost between a read and the following clear
  // The timeout status bit follows the same rule

  // Sticky status: set wins over write-one-to-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= {`IRQ_WIDTH{1'b0}};
      irq_mask_q <= {`IRQ_WIDTH{1'b0}};
      timeout_q  <= 1'b0;
    end else if (clk_en) begin
      irq_stat_q <= (irq_stat_q & ~(irq_stat_wr ? pwdata[`IRQ_WIDTH-1:0]
                                                : {`IRQ_WIDTH{1'b0}})) | irq_set;
      if (wr && mapped && (idx == `IDX_IRQ_MASK)) begin
        irq_mask_q <= pwdata[`IRQ_WIDTH-1:0];
      end
      // Timeout status follows only while selective wake runs
      if (to_update) begin
        timeout_q <= 1'b1;
      end else if (bstat_wr && pwdata[0]) begin
        timeout_q <= 1'b0;
      end
    end
  end

  // Read notes
  // Read data is chosen from the address in the setup phase
  // Reserved fields are masked here as well as on write
  // The block status word shows live internal state for debug

  // Read data mux; reserved bits read as zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `IDX_SELECTIVE_WAKE_CONTROL:  rd_byte = ctl_q & `CTL_WRITE_MASK;
      `IDX_WAKE_BIT_TIME_QUANTA:    rd_byte = quanta_q;
      `IDX_WAKE_SAMPLE_POINT:       rd_byte = sample_q & `SAMPLE_MASK;
      `IDX_WAKE_FRAME_ID_HIGH:      rd_byte = id_high_q;
      `IDX_WAKE_FRAME_ID_UPPER_MID: rd_byte = id_umid_q;
      `IDX_WAKE_FRAME_ID_LOWER_MID: rd_byte = id_lmid_q;
      `IDX_WAKE_FRAME_ID_LOW_FLAGS: rd_byte = id_low_q & `ID_LOW_MASK;
      `IDX_WAKE_OPTION_REGISTER:    rd_byte = option_q;
      `IDX_IRQ_STATUS:              rd_byte = {5'h00, irq_stat_q};
      `IDX_IRQ_MASK:                rd_byte = {5'h00, irq_mask_q};
      `IDX_BLOCK_STATUS:            rd_byte = {4'h0, txd_q, unlocked, sw_on, timeout_q};
      default:                      rd_byte = 8'h00;
    endcase
  end

  // Bus answer notes
  // pready, pslverr and prdata are registered in the setup phase
  // pready and pslverr stand for exactly the access-phase cycle; prdata holds its value
  // A master that inserts its own idle cycle sees pready low again
  // Read data is zero for writes and for unmapped addresses

  // APB answer: one-cycle pulse of pready in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (psel && !penable) begin
        // Setup cycle: prepare answer for the access phase
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= (mapped && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Output stage notes
  // Every output comes straight from a flip-flop
  // This costs one clock of latency but keeps the matching logic
  // free of glitches from the bus decode
  // The trim reference idles high while calibration is off

  // Registered configuration outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selective_wake_en      <= 1'b0;
      oscillator_trim_enable <= 1'b0;
      trim_unlocked          <= 1'b0;
      trim_reference         <= 1'b1;
      quanta_per_bit         <= `RST_QUANTA;
      sample_point_fraction  <= 6'h33;
      quantum_clock_sel_out  <= 2'h0;
      wake_frame_id          <= 29'h00000000;
      wake_frame_rtr         <= 1'b0;
      wake_frame_ide         <= 1'b0;
      wake_option_out        <= `RST_OPTION;
      bus_timeout_status     <= 1'b0;
      irq                    <= 1'b0;
    end else if (clk_en) begin
      selective_wake_en      <= ctl_q[`CTL_VALID_BIT];
      oscillator_trim_enable <= ctl_q[`CTL_TRIM_EN_BIT];
      trim_unlocked          <= unlocked;
      // Trim reference taken from the pin only during calibration
      trim_reference         <= ctl_q[`CTL_TRIM_EN_BIT] ? txd_q : 1'b1;
      quanta_per_bit         <= quanta_q;
      sample_point_fraction  <= sample_q[5:0];
      // Quantum length set by the clock select field
      quantum_clock_sel_out  <= quantum_clock_select;
      // Standard ids occupy 28..18; low bits only used when extended
      wake_frame_id          <= {id_high_q, id_umid_q, id_lmid_q, id_low_q[6:2]};
      wake_frame_rtr         <= id_low_q[1];
      wake_frame_ide         <= id_low_q[0];
      wake_option_out        <= option_q;
      bus_timeout_status     <= timeout_q;
      irq                    <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

`default_nettype wire

//--- dv/wake_cfg_regs_assertions.sv
// Concurrent checks on the selective-wake bank ports
`default_nettype none
module wake_cfg_regs_chk (
  // Clock, reset, enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Events and outputs
  input wire logic        wake_event,
  input wire logic        bus_timeout_event,
  input wire logic        selective_wake_en,
  input wire logic        oscillator_trim_enable,
  input wire logic        trim_unlocked,
  input wire logic [7:0]  quanta_per_bit,
  input wire logic [5:0]  sample_point_fraction,
  input wire logic [7:0]  wake_option_out,
  input wire logic        bus_timeout_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed accesses; outputs show a write two edges after it lands
  wire acc    = psel && penable && pready && clk_en;
  wire wr_ctl = acc && pwrite && pstrb[0] && paddr == 12'h080;
  wire wr_opt = acc && pwrite && pstrb[0] && paddr == 12'h09C;
  a_key_unlock: assert property (wr_ctl |-> ##2 trim_unlocked == &$past(pwdata[6:5], 2))
    else $error("unlock flag wrong");
  a_locked_trim: assert property (
    wr_ctl && !trim_unlocked |-> ##2 oscillator_trim_enable == $past(oscillator_trim_enable, 2))
    else $error("locked trim enable changed");
  a_trim_follow: assert property (
    wr_ctl && trim_unlocked |-> ##2 oscillator_trim_enable == $past(pwdata[7], 2))
    else $error("trim enable ignored");
  a_opt_lock: assert property (
    wr_opt && !trim_unlocked |-> ##2 wake_option_out == $past(wake_option_out, 2))
    else $error("locked option changed");
  a_reads_zero: assert property (
    acc && !pwrite |-> prdata[31:8] == 24'h0 && (paddr != 12'h080 || prdata[3:1] == 3'h0)
    && (paddr != 12'h088 || prdata[7:6] == 2'h0) && (paddr != 12'h098 || !prdata[7]))
    else $error("reserved bits not zero");
  a_wake_clear: assert property (wake_event && clk_en |-> ##2 !selective_wake_en)
    else $error("valid flag kept after wake");
  a_timeout_gate: assert property (
    bus_timeout_event && clk_en && !$past(bus_timeout_event) && !bus_timeout_status
    ##1 !selective_wake_en |=> !bus_timeout_status) else $error("timeout set while disabled");
  a_reset_vals: assert property ($rose(presetn) |-> quanta_per_bit == 8'hA0
    && sample_point_fraction == 6'h33) else $error("reset values wrong");
  // Main scenarios
  cover property (wr_ctl && trim_unlocked);
  cover property (bus_timeout_status);
  cover property (wr_opt && trim_unlocked);
endmodule
bind wake_cfg_regs wake_cfg_regs_chk i_chk (.*);
`default_nettype wire

//--- dv/wake_host.sv
// Bus master model of the host controller that programs the bank
`default_nettype none
module wake_host (
  // Clock
  input  wire logic        pclk,
  // Request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic [3:0]  pstrb,
  // Answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle from time zero
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // One transfer, held until pready is seen at an edge or 16 edges have passed
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    ok = 1'b0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 3'h0, w};
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge pclk);
      ok = pready;
    end
    rd = prdata;
    err = pslverr;
    // Released address and data lines carry inverted values so stale data cannot pass
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

//--- dv/wake_cfg_regs_tb.sv
// Self-checking bench for the selective-wake configuration bank
`default_nettype none
module wake_cfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Bench-driven inputs
  logic       pclk, presetn, clk_en, transceiver_tx_input_pin;
  logic       restart_entry, wake_event, bus_timeout_event;
  logic [1:0] quantum_clock_select;
  // Bus and design outputs
  wire        psel, penable, pwrite, pready, pslverr, irq, bus_timeout_status;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0]  pstrb;
  wire        selective_wake_en, oscillator_trim_enable, trim_unlocked, trim_reference;
  wire [7:0]  quanta_per_bit, wake_option_out;
  wire [5:0]  sample_point_fraction;
  wire [1:0]  quantum_clock_sel_out;
  wire [28:0] wake_frame_id;
  wire        wake_frame_rtr, wake_frame_ide;
  // Bookkeeping
  int          n_fail, compares;
  logic [31:0] rd;
  logic        err, ok;

  wake_cfg_regs i_dut (.*);
  wake_host i_host (.*);

  // Compare and count; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Transfer to a register index; a hung bus ends the run
  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
    i_host.xfer(w, {3'h0, idx, 2'h0}, {24'h0, d}, rd, err, ok);
    if (!ok) begin
      chk(32'h0, 32'h1);
      stop_test();
    end
  endtask
  task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  // Outputs trail the bank registers by one edge
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // One-cycle pulse of {restart, wake, timeout}
  task automatic pulse(input logic [2:0] p);
    @(posedge pclk);
    {restart_entry, wake_event, bus_timeout_event} <= p;
    @(posedge pclk);
    {restart_entry, wake_event, bus_timeout_event} <= 3'h0;
  endtask

  // Reset values and an unmapped index
  task automatic t_reset();
    rdchk(7'h21, 8'hA0);
    rdchk(7'h22, 8'h33);
    rdchk(7'h20, 8'h00);
    chk(selective_wake_en, 1'b0);
    chk(quantum_clock_sel_out, 2'h2);
    bus(1'b0, 7'h2C, 8'h00);
    chk({err, rd[30:0]}, 32'h80000000);
  endtask
  // Identifier layout, frame flags, reserved bits
  task automatic t_ids();
    bus(1'b1, 7'h23, 8'hA5);
    bus(1'b1, 7'h24, 8'h3C);
    bus(1'b1, 7'h25, 8'h96);
    bus(1'b1, 7'h26, 8'hF9);
    bus(1'b1, 7'h22, 8'hFF);
    settle();
    chk(wake_frame_id, {8'hA5, 8'h3C, 8'h96, 5'h1E});
    chk(wake_frame_id[28:18], 11'h529);
    chk({wake_frame_rtr, wake_frame_ide}, 2'h1);
    rdchk(7'h26, 8'h79);
    chk(sample_point_fraction, 6'h3F);
  endtask
  // Valid flag set by host, dropped by config change and wake
  task automatic t_valid();
    bus(1'b1, 7'h20, 8'h01);
    settle();
    chk(selective_wake_en, 1'b1);
    bus(1'b1, 7'h21, 8'h5A);
    settle();
    chk({selective_wake_en, quanta_per_bit}, 9'h05A);
    bus(1'b1, 7'h20, 8'h01);
    pulse(3'b010);
    settle();
    chk(selective_wake_en, 1'b0);
  endtask
  // Every key value, locked writes, calibration and restart
  task automatic t_unlock();
    bus(1'b1, 7'h27, 8'h55);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 7'h20, {1'b1, k[1:0], 5'h01});
      settle();
      chk({oscillator_trim_enable, trim_unlocked}, {1'b0, k == 3});
    end
    rdchk(7'h27, 8'h00);
    bus(1'b1, 7'h27, 8'h55);
    bus(1'b1, 7'h20, 8'hE1);
    transceiver_tx_input_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({oscillator_trim_enable, trim_reference}, 2'h2);
    chk(wake_option_out, 8'h55);
    pulse(3'b100);
    rdchk(7'h20, 8'hE0);
  endtask
  // Timeout gating, interrupt raise, mask and clear
  task automatic t_irq();
    bus(1'b1, 7'h28, 8'h07);
    bus(1'b1, 7'h29, 8'h01);
    bus(1'b1, 7'h20, 8'h10);
    pulse(3'b001);
    settle();
    chk({bus_timeout_status, irq}, 2'h0);
    bus(1'b1, 7'h20, 8'h11);
    pulse(3'b001);
    settle();
    chk({bus_timeout_status, irq}, 2'h3);
    bus(1'b1, 7'h29, 8'h00);
    settle();
    chk(irq, 1'b0);
    bus(1'b1, 7'h28, 8'h07);
    bus(1'b1, 7'h20, 8'h01);
    bus(1'b1, 7'h29, 8'h01);
    pulse(3'b001);
    settle();
    chk(irq, 1'b0);
    rdchk(7'h2A, 8'h03);
    bus(1'b1, 7'h2A, 8'h01);
    rdchk(7'h2A, 8'h02);
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, restart_entry, wake_event, bus_timeout_event} = 4'h0;
    {clk_en, transceiver_tx_input_pin} = 2'h3;
    quantum_clock_select = 2'h2;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ids();
    t_valid();
    t_unlock();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
